// ===== bench/induction_motor_model.sv
// Behavioural induction motor at the far side of the drive output stage.
// Assumes out_freq in 0.01 Hz units; shaft_speed uses the same units on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module induction_motor_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] out_freq,
	input wire logic out_enable,
	input wire logic dc_inject,
	input wire logic [10:0] dc_current,
	output logic [15:0] shaft_speed
);
	// Lags the drive while powered, coasts down slowly when free, stops fast under DC
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shaft_speed <= 16'h0000;
		end else if (dc_inject && dc_current != 11'h000) begin
			shaft_speed <= (shaft_speed > 16'h0040) ? shaft_speed - 16'h0040 : 16'h0000;
		end else if (out_enable) begin
			shaft_speed <= (shaft_speed < out_freq) ?
				out_freq - ((out_freq - shaft_speed) >> 1) : out_freq;
		end else begin
			shaft_speed <= shaft_speed - (shaft_speed >> 6);
		end
	end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the drive frequency, stop and DC brake block.
// Assumes the design sources on the include path; tick counts shortened.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int TC = 10;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic run_cmd = 1'b0, reverse = 1'b0, terminal_in3 = 1'b0, cmd_from_link = 1'b0;
	logic boost_select = 1'b0, limit_select = 1'b0, skip_select = 1'b1;
	logic [4:0] input3_function_select = 5'h0A;
	logic [15:0] freq_cmd = 16'h0BB8, accel_step = 16'h00C8, decel_step = 16'h00C8;
	logic [1:0] vf_pattern_select = 2'h0, stop_mode_select = 2'h0, load_inertia_ratio = 2'h0;
	logic [6:0] vf_volt_pct = 7'h50, out_volt_adjust_pct = 7'h64;
	logic [3:0] fwd_boost_pct = 4'h2, rev_boost_pct = 4'h2;
	logic [9:0] no_load_current = 10'h080, motor_rated_current = 10'h3FF;
	logic [7:0] stator_resistance = 8'h40, stop_brake_level = 8'h32, start_brake_level = 8'h32;
	logic [9:0] brake_wait_time = 10'h002, stop_brake_duration = 10'h003;
	logic [9:0] start_brake_duration = 10'h002;
	logic [15:0] brake_start_freq = 16'h01F4, max_freq = 16'h1770, start_freq = 16'h0032;
	logic [15:0] high_freq_limit = 16'h1388, low_freq_limit = 16'h012C;
	logic [15:0] skip_band1_low = 16'h03E8, skip_band1_high = 16'h05DC;
	logic [15:0] skip_band2_low = 16'h09C4, skip_band2_high = 16'h0BB8;
	logic [15:0] skip_band3_low = 16'h0FA0, skip_band3_high = 16'h1194;
	logic [15:0] out_freq, shaft_speed, tgt = 16'h0000;
	logic [7:0] out_volt_pct, seen = 8'h00;
	logic out_enable, dc_inject, thru = 1'b0;
	logic [10:0] dc_current;
	logic [1:0] brake_gain;
	logic [2:0] drive_state;
	logic [17:0] tab [9] = '{18'h01770, 18'h01771, 18'h00031, 18'h20031, 18'h21770,
		18'h31770, 18'h004B0, 18'h00100, 18'h004B0};
	int n_mismatch = 0, n_checks = 0;
	drive_freq_limit_stop_brake #(.TENTH_CYCLES(TC), .RAMP_CYCLES(4)) u_dut (.*);
	induction_motor_model u_motor (.*);
	always #4 sys_clk = ~sys_clk;
	// States visited, and whether a ramp crossed the inside of skip band 2
	always @(negedge sys_clk) begin
		seen[drive_state] <= 1'b1;
		if (out_freq > skip_band2_low && out_freq < skip_band2_high)
			thru <= 1'b1;
	end
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_on(input bit fr, input logic [15:0] v);
		int i;
		i = 0;
		while ((fr ? out_freq : 16'(drive_state)) !== v && i < 2000) begin
			@(negedge sys_clk);
			i++;
		end
		if (fr)
			repeat (9) @(negedge sys_clk);
		chk(fr ? out_freq : 16'(drive_state), v);
	endtask
	task automatic cnt(input logic [2:0] s, input int lo, input int hi);
		int n;
		n = 0;
		while (drive_state === s && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(16'(n >= lo && n <= hi), 16'h0001);
	endtask
	function automatic logic [15:0] skip1(input logic [15:0] t, p, lo, hi);
		return (skip_select && t > lo && t < hi) ? ((t > p) ? lo : hi) : t;
	endfunction
	function automatic logic [15:0] exp_tgt(input logic [15:0] c, p);
		logic [15:0] t;
		if (c > max_freq)
			return p;
		t = c;
		if (limit_select && !cmd_from_link)
			t = (t > high_freq_limit) ? high_freq_limit : (t < low_freq_limit) ? low_freq_limit : t;
		t = skip1(t, p, skip_band1_low, skip_band1_high);
		t = skip1(t, p, skip_band2_low, skip_band2_high);
		t = skip1(t, p, skip_band3_low, skip_band3_high);
		return (t < start_freq) ? 16'h0000 : t;
	endfunction
	function automatic logic [15:0] exp_dc(input logic [7:0] l);
		return 16'((32'(l) * 32'(motor_rated_current)) / 32'h64);
	endfunction
	function automatic logic [15:0] exp_volt();
		int b, a;
		b = reverse ? rev_boost_pct : fwd_boost_pct;
		if (boost_select)
			b = (no_load_current * stator_resistance) >> 8;
		b = (b > 32'hF) ? 32'hF : b;
		if (vf_pattern_select == 2'h2)
			b = 0;
		a = (out_volt_adjust_pct < 7'h28) ? 32'h28 : (out_volt_adjust_pct > 7'h6E) ? 32'h6E :
			out_volt_adjust_pct;
		return 16'((vf_volt_pct + b) * a / 32'h64);
	endfunction
	task automatic do_stop(input logic [1:0] m, input logic [7:0] lv, input logic [9:0] du);
		stop_mode_select = m;
		stop_brake_level = lv;
		stop_brake_duration = du;
		seen = 8'h00;
		run_cmd = 1'b1;
		wait_on(1'b0, 16'h0002);
		chk(16'(seen[1]), 16'h0000);
		wait_on(1'b1, tgt);
		seen = 8'h00;
		run_cmd = 1'b0;
		if (m == 2'h2) begin
			repeat (5) @(negedge sys_clk);
			chk(out_freq, 16'h0000);
			chk(16'({out_enable, out_volt_pct, seen[3], drive_state}), 16'h0000);
		end else if (m != 2'h1 || lv == 8'h00 || du == 10'h000) begin
			wait_on(1'b0, 16'h0003);
			wait_on(1'b1, 16'h0000);
			wait_on(1'b0, 16'h0000);
			chk(16'(seen[5]), 16'h0000);
		end else begin
			wait_on(1'b0, 16'h0004);
			chk(16'({seen[3], out_enable, dc_inject}), 16'h0004);
			cnt(3'h4, TC - 1, TC * 2 + 2);
			chk(16'({drive_state, dc_inject}), 16'h000B);
			chk(16'(dc_current), exp_dc(lv));
			cnt(3'h5, TC * (du - 1) - 1, TC * du + 2);
			chk(16'(drive_state), 16'h0000);
			chk(shaft_speed, 16'h0000);
		end
	endtask
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end
	initial begin
		void'($urandom(32'h0849));
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(16'({out_enable, dc_inject, drive_state}), 16'h0000);
		for (int r = 0; r < 4; r++) begin
			load_inertia_ratio = 2'(r);
			repeat (3) @(negedge sys_clk);
			chk(16'(brake_gain), (r == 3) ? 16'h0002 : 16'(r));
		end
		terminal_in3 = 1'b1;
		repeat (10) @(negedge sys_clk);
		chk(16'(drive_state), 16'h0000);
		input3_function_select = 5'h0B;
		wait_on(1'b0, 16'h0006);
		chk(16'(dc_current), exp_dc(start_brake_level));
		terminal_in3 = 1'b0;
		wait_on(1'b0, 16'h0000);
		run_cmd = 1'b1;
		tgt = exp_tgt(freq_cmd, tgt);
		wait_on(1'b0, 16'h0001);
		chk(16'(dc_current), exp_dc(start_brake_level));
		chk(out_freq, 16'h0000);
		cnt(3'h1, TC - 1, TC * 2 + 2);
		wait_on(1'b1, tgt);
		for (int k = 0; k < 21; k++) begin
			if (k < 9)
				{limit_select, cmd_from_link, freq_cmd} = tab[k];
			else
				{limit_select, cmd_from_link, skip_select, freq_cmd} =
					{3'($urandom), 16'($urandom_range(0, 32'h1B58))};
			tgt = exp_tgt(freq_cmd, tgt);
			wait_on(1'b1, tgt);
		end
		chk(16'(thru), 16'h0001);
		for (int k = 0; k < 12; k++) begin
			{reverse, boost_select, fwd_boost_pct, rev_boost_pct} = 10'($urandom);
			vf_pattern_select = 2'($urandom_range(0, 2));
			vf_volt_pct = 7'($urandom_range(0, 32'h64));
			out_volt_adjust_pct = 7'($urandom_range(32'h1E, 32'h78));
			{no_load_current, stator_resistance} = 18'($urandom);
			repeat (4) @(negedge sys_clk);
			chk(16'(out_volt_pct), exp_volt());
		end
		{limit_select, cmd_from_link, skip_select, freq_cmd} = {3'h1, 16'h0BB8};
		tgt = exp_tgt(freq_cmd, tgt);
		start_brake_level = 8'h00;
		do_stop(2'h2, 8'h32, 10'h003);
		do_stop(2'h0, 8'h32, 10'h003);
		do_stop(2'h3, 8'h32, 10'h003);
		start_brake_level = 8'h32;
		start_brake_duration = 10'h000;
		do_stop(2'h1, 8'h00, 10'h003);
		do_stop(2'h1, 8'h32, 10'h000);
		do_stop(2'h1, 8'($urandom_range(1, 32'hC8)), 10'($urandom_range(2, 5)));
		do_stop(2'h1, 8'hC8, 10'h002);
		close_out();
	end
endmodule
`default_nettype wire

// ===== hw/drive_defines.svh
// Constants for the drive frequency, stop and brake control block.
// Frequencies are 0.01 Hz units, times 0.1 s units, levels in percent.
`ifndef DRIVE_DEFINES_SVH
`define DRIVE_DEFINES_SVH
`define CLK_MHZ 125
`define TENTH_S_US 100000
`define RAMP_TICK_US 1000
`define STOP_DECEL 2'h0
`define STOP_DCBRAKE 2'h1
`define STOP_COAST 2'h2
`define VF_USER 2'h2
`define BOOST_MANUAL 1'h0
`define BOOST_AUTO 1'h1
`define FUNC_DC_HOLD 5'h0B
`define BOOST_MAX 4'hF
`define AUTO_BOOST_SHIFT 8
`define ADJ_MIN 7'h28
`define ADJ_MAX 7'h6E
`define PCT_DIV 7'h64
`define GAIN_LOW 2'h0
`define GAIN_MID 2'h1
`define GAIN_HIGH 2'h2
`define FREQ_ZERO 16'h0000
`endif

// ===== hw/drive_freq_limit_stop_brake.sv
// Frequency limiting, torque boost, voltage scaling and stop/DC brake sequencing.
// Assumes settings come from logic on sys_clk; run_cmd and terminal_in3 are pins.
//
// Behaviour
// RULE1: Pattern select value 2 chooses the user volts-per-hertz pattern.
// RULE2: User pattern active means forward and reverse manual boost are ignored.
// RULE3: Output voltage scaled by adjust percent, range 40 to 110, default 100.
// RULE4: Boost select 0 applies manual boost, separate forward and reverse percent.
// RULE5: Boost select 1 computes boost from no-load current and stator resistance.
// RULE6: Stop mode 0 ramps output down to 0 Hz at decel rate.
// RULE7: Stop mode 2 cuts frequency and voltage at once on run removal.
// RULE8: Stop mode 1 decelerates to brake start frequency, then starts DC brake.
// RULE9: At brake start frequency, output stays off for the brake wait time.
// RULE10: After the wait, DC is injected for the brake duration, then stop.
// RULE11: Stop brake level is a percent of rated motor current, 0 to 200.
// RULE12: Zero stop brake level or duration skips DC braking entirely.
// RULE13: Run command first injects start brake level for start brake duration.
// RULE14: Zero start brake level or duration omits DC injection at start.
// RULE15: Input function 11 holds DC at start brake level while stopped.
// RULE16: Frequency commands above maximum frequency are rejected.
// RULE17: Commands below start frequency become 0.00.
// RULE18: Limit select 1 clamps analog and keypad commands between high and low limits.
// RULE19: Skip select 1 never settles inside any of three skip bands.
// RULE20: Ramping passes through skip bands instead of jumping over them.
// RULE21: Rising setpoint inside a band holds at the band's lower edge.
// RULE22: Falling setpoint inside a band holds at the band's upper edge.
// RULE23: Configuring party keeps skip edges between start and maximum frequency.
// RULE24: Inertia ratio 0, 1, 2 selects low, mid, high DC brake gain.
// RULE25: Limit select 0 applies only maximum and start frequency bounds.
`timescale 1ns/100ps
`default_nettype none
`include "drive_defines.svh"
module drive_freq_limit_stop_brake #(
	parameter int TENTH_CYCLES = `TENTH_S_US * `CLK_MHZ,
	parameter int RAMP_CYCLES = `RAMP_TICK_US * `CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run_cmd,
	input wire logic reverse,
	input wire logic terminal_in3,
	input wire logic [4:0] input3_function_select,
	input wire logic [15:0] freq_cmd,
	input wire logic cmd_from_link,
	input wire logic [15:0] accel_step,
	input wire logic [15:0] decel_step,
	input wire logic [1:0] vf_pattern_select,
	input wire logic [6:0] vf_volt_pct,
	input wire logic [6:0] out_volt_adjust_pct,
	input wire logic boost_select,
	input wire logic [3:0] fwd_boost_pct,
	input wire logic [3:0] rev_boost_pct,
	input wire logic [9:0] no_load_current,
	input wire logic [7:0] stator_resistance,
	input wire logic [1:0] stop_mode_select,
	input wire logic [15:0] brake_start_freq,
	input wire logic [9:0] brake_wait_time,
	input wire logic [7:0] stop_brake_level,
	input wire logic [9:0] stop_brake_duration,
	input wire logic [7:0] start_brake_level,
	input wire logic [9:0] start_brake_duration,
	input wire logic [9:0] motor_rated_current,
	input wire logic [1:0] load_inertia_ratio,
	input wire logic [15:0] max_freq,
	input wire logic [15:0] start_freq,
	input wire logic limit_select,
	input wire logic [15:0] high_freq_limit,
	input wire logic [15:0] low_freq_limit,
	input wire logic skip_select,
	input wire logic [15:0] skip_band1_low,
	input wire logic [15:0] skip_band1_high,
	input wire logic [15:0] skip_band2_low,
	input wire logic [15:0] skip_band2_high,
	input wire logic [15:0] skip_band3_low,
	input wire logic [15:0] skip_band3_high,
	output logic [15:0] out_freq,
	output logic [7:0] out_volt_pct,
	output logic out_enable,
	output logic dc_inject,
	output logic [10:0] dc_current,
	output logic [1:0] brake_gain,
	output logic [2:0] drive_state
);
	initial begin
		if (TENTH_CYCLES < 1 || RAMP_CYCLES < 1)
			$error("tick counts must be at least one cycle");
	end

	logic rst_q1, rst_s;
	logic run_q1, run_s, in3_q1, in3_s;
	logic [31:0] tenth_cnt, ramp_cnt;
	logic tenth_tick, ramp_tick;
	logic [15:0] target, next_target;
	logic [9:0] tmr;
	drive_pkg::drive_state_e state, next_state;
	logic hold_req, start_dc_on, stop_dc_on;
	logic [3:0] boost_pct;
	logic [15:0] ramp_goal;

	function automatic logic in_band(input logic [15:0] f, input logic [15:0] lo,
		input logic [15:0] hi);
		in_band = (f > lo) && (f < hi);
	endfunction

	function automatic logic [10:0] pct_of(input logic [7:0] pct, input logic [9:0] base);
		logic [17:0] prod;
		prod = 18'(pct) * 18'(base);
		pct_of = 11'(prod / 18'(`PCT_DIV));
	endfunction

	function automatic logic [3:0] auto_boost(input logic [9:0] i0, input logic [7:0] rs);
		logic [17:0] p;
		p = (18'(i0) * 18'(rs)) >> `AUTO_BOOST_SHIFT;
		auto_boost = (p > 18'(`BOOST_MAX)) ? `BOOST_MAX : 4'(p);
	endfunction

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q1 <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_s <= rst_q1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			run_q1 <= 1'b0;
			run_s <= 1'b0;
			in3_q1 <= 1'b0;
			in3_s <= 1'b0;
		end else begin
			run_q1 <= run_cmd;
			run_s <= run_q1;
			in3_q1 <= terminal_in3;
			in3_s <= in3_q1;
		end
	end

	// Tenth-second tick times the brake phases; millisecond tick paces the ramp
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			tenth_cnt <= 32'h0;
			tenth_tick <= 1'b0;
			ramp_cnt <= 32'h0;
			ramp_tick <= 1'b0;
		end else begin
			tenth_tick <= (tenth_cnt == 32'(TENTH_CYCLES - 1));
			tenth_cnt <= (tenth_cnt == 32'(TENTH_CYCLES - 1)) ? 32'h0 : tenth_cnt + 32'h1;
			ramp_tick <= (ramp_cnt == 32'(RAMP_CYCLES - 1));
			ramp_cnt <= (ramp_cnt == 32'(RAMP_CYCLES - 1)) ? 32'h0 : ramp_cnt + 32'h1;
		end
	end

	// Command shaping: reject, clamp, skip, then start cut
	always_comb begin
		logic [15:0] f;
		f = freq_cmd;
		next_target = target;
		if (freq_cmd <= max_freq) begin //RULE16
			if (limit_select && !cmd_from_link) begin //RULE18
				if (f > high_freq_limit)
					f = high_freq_limit;
				if (f < low_freq_limit)
					f = low_freq_limit;
			end //RULE25
			if (skip_select) begin //RULE19
				if (in_band(f, skip_band1_low, skip_band1_high))
					f = (f > target) ? skip_band1_low : skip_band1_high; //RULE21 RULE22
				else if (in_band(f, skip_band2_low, skip_band2_high))
					f = (f > target) ? skip_band2_low : skip_band2_high; //RULE21 RULE22
				else if (in_band(f, skip_band3_low, skip_band3_high))
					f = (f > target) ? skip_band3_low : skip_band3_high; //RULE21 RULE22
			end
			next_target = (f < start_freq) ? `FREQ_ZERO : f; //RULE17
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s)
			target <= `FREQ_ZERO;
		else
			target <= next_target;
	end

	assign hold_req = in3_s && (input3_function_select == `FUNC_DC_HOLD); //RULE15
	assign start_dc_on = (start_brake_level != 8'h00) && (start_brake_duration != 10'h000);
	assign stop_dc_on = (stop_brake_level != 8'h00) && (stop_brake_duration != 10'h000);

	always_comb begin
		next_state = state;
		case (state)
			drive_pkg::ST_IDLE: begin
				if (run_s)
					next_state = start_dc_on ? drive_pkg::ST_START_DC
						: drive_pkg::ST_RUN; //RULE13 RULE14
				else if (hold_req)
					next_state = drive_pkg::ST_HOLD_DC; //RULE15
			end
			drive_pkg::ST_HOLD_DC: begin
				if (run_s || !hold_req)
					next_state = drive_pkg::ST_IDLE;
			end
			drive_pkg::ST_START_DC: begin
				if (!run_s)
					next_state = drive_pkg::ST_IDLE;
				else if (tmr >= start_brake_duration)
					next_state = drive_pkg::ST_RUN; //RULE13
			end
			drive_pkg::ST_RUN: begin
				if (!run_s)
					next_state = (stop_mode_select == `STOP_COAST) ? drive_pkg::ST_IDLE
						: drive_pkg::ST_DECEL; //RULE7 RULE6
			end
			drive_pkg::ST_DECEL: begin
				if (run_s)
					next_state = drive_pkg::ST_RUN;
				else if (stop_mode_select == `STOP_DCBRAKE && stop_dc_on
					&& out_freq <= brake_start_freq)
					next_state = drive_pkg::ST_BRAKE_WAIT; //RULE8 RULE12
				else if (out_freq == `FREQ_ZERO)
					next_state = drive_pkg::ST_IDLE; //RULE6
			end
			drive_pkg::ST_BRAKE_WAIT: begin
				if (tmr >= brake_wait_time)
					next_state = drive_pkg::ST_BRAKE_DC; //RULE9
			end
			drive_pkg::ST_BRAKE_DC: begin
				if (tmr >= stop_brake_duration)
					next_state = drive_pkg::ST_IDLE; //RULE10
			end
			default: next_state = drive_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s)
			state <= drive_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Phase timer in tenths of a second, restarted on every state change
	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s)
			tmr <= 10'h000;
		else if (next_state != state)
			tmr <= 10'h000;
		else if (tenth_tick && tmr != 10'h3FF)
			tmr <= tmr + 10'h001;
	end

	// Ramp walks through skip bands in steps of accel_step or decel_step
	assign ramp_goal = (state == drive_pkg::ST_RUN) ? target : `FREQ_ZERO;

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s)
			out_freq <= `FREQ_ZERO;
		else if (next_state != drive_pkg::ST_RUN && next_state != drive_pkg::ST_DECEL)
			out_freq <= `FREQ_ZERO; //RULE7
		else if (ramp_tick) begin
			if (out_freq < ramp_goal)
				out_freq <= (ramp_goal - out_freq > accel_step) ? out_freq + accel_step
					: ramp_goal; //RULE20
			else if (out_freq > ramp_goal)
				out_freq <= (out_freq - ramp_goal > decel_step) ? out_freq - decel_step
					: ramp_goal; //RULE6 RULE20
		end
	end

	always_comb begin
		if (vf_pattern_select == `VF_USER)
			boost_pct = 4'h0; //RULE1 RULE2
		else if (boost_select == `BOOST_AUTO)
			boost_pct = auto_boost(no_load_current, stator_resistance); //RULE5
		else
			boost_pct = reverse ? rev_boost_pct : fwd_boost_pct; //RULE4
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		logic [6:0] adj;
		logic [15:0] prod;
		if (!rst_s) begin
			out_volt_pct <= 8'h00;
		end else begin
			adj = out_volt_adjust_pct;
			if (adj < `ADJ_MIN)
				adj = `ADJ_MIN;
			if (adj > `ADJ_MAX)
				adj = `ADJ_MAX;
			prod = (16'(vf_volt_pct) + 16'(boost_pct)) * 16'(adj);
			if (next_state == drive_pkg::ST_RUN || next_state == drive_pkg::ST_DECEL)
				out_volt_pct <= 8'(prod / 16'(`PCT_DIV)); //RULE3
			else
				out_volt_pct <= 8'h00; //RULE7 RULE9
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			out_enable <= 1'b0;
			dc_inject <= 1'b0;
			dc_current <= 11'h000;
			drive_state <= 3'h0;
		end else begin
			out_enable <= (next_state == drive_pkg::ST_RUN)
				|| (next_state == drive_pkg::ST_DECEL);
			drive_state <= next_state;
			case (next_state)
				drive_pkg::ST_BRAKE_DC: begin
					dc_inject <= 1'b1;
					dc_current <= pct_of(stop_brake_level, motor_rated_current); //RULE11 RULE10
				end
				drive_pkg::ST_START_DC, drive_pkg::ST_HOLD_DC: begin
					dc_inject <= 1'b1;
					dc_current <= pct_of(start_brake_level, motor_rated_current); //RULE13 RULE15
				end
				default: begin
					dc_inject <= 1'b0;
					dc_current <= 11'h000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s)
			brake_gain <= `GAIN_LOW;
		else if (load_inertia_ratio == 2'h0)
			brake_gain <= `GAIN_LOW; //RULE24
		else if (load_inertia_ratio == 2'h1)
			brake_gain <= `GAIN_MID; //RULE24
		else
			brake_gain <= `GAIN_HIGH; //RULE24
	end

	property p_reject;
		@(posedge sys_clk) disable iff (!rst_s)
		(freq_cmd > max_freq) |=> (target == $past(target));
	endproperty
	a_reject: assert property (p_reject) else $error("over-max command changed target"); //RULE16

	property p_start_cut;
		@(posedge sys_clk) disable iff (!rst_s)
		(target != 16'h0000) |-> (target >= $past(start_freq));
	endproperty
	a_start_cut: assert property (p_start_cut) else $error("target below start freq"); //RULE17

	property p_limit;
		@(posedge sys_clk) disable iff (!rst_s)
		($past(limit_select) && !$past(cmd_from_link) && $past(freq_cmd) <= $past(max_freq)
			&& !$past(skip_select)) |-> (target == 16'h0000 || target <= $past(high_freq_limit));
	endproperty
	a_limit: assert property (p_limit) else $error("target above high limit"); //RULE18

	property p_coast;
		@(posedge sys_clk) disable iff (!rst_s)
		(state == drive_pkg::ST_RUN && !run_s && stop_mode_select == `STOP_COAST)
			|-> ##1 (out_freq == 16'h0000 && !out_enable && out_volt_pct == 8'h00);
	endproperty
	a_coast: assert property (p_coast) else $error("coast did not cut output"); //RULE7

	property p_wait_off;
		@(posedge sys_clk) disable iff (!rst_s)
		(state == drive_pkg::ST_BRAKE_WAIT && next_state == drive_pkg::ST_BRAKE_WAIT)
			|=> (!out_enable && !dc_inject);
	endproperty
	a_wait_off: assert property (p_wait_off) else $error("output active in brake wait"); //RULE9

	property p_skip_dc;
		@(posedge sys_clk) disable iff (!rst_s)
		(state == drive_pkg::ST_DECEL && (stop_brake_level == 8'h00
			|| stop_brake_duration == 10'h000)) |=> (state != drive_pkg::ST_BRAKE_WAIT);
	endproperty
	a_skip_dc: assert property (p_skip_dc) else $error("brake entered while disabled"); //RULE12

	property p_start_dc;
		@(posedge sys_clk) disable iff (!rst_s)
		(state == drive_pkg::ST_IDLE && run_s) |=>
			(start_dc_on ? state == drive_pkg::ST_START_DC : state == drive_pkg::ST_RUN);
	endproperty
	a_start_dc: assert property (p_start_dc) else $error("wrong start sequence"); //RULE13

	property p_hold;
		@(posedge sys_clk) disable iff (!rst_s)
		(state == drive_pkg::ST_IDLE && !run_s && hold_req) |=> ##0 dc_inject;
	endproperty
	a_hold: assert property (p_hold) else $error("hold DC not injected"); //RULE15

	property p_ramp;
		@(posedge sys_clk) disable iff (!rst_s)
		(state == drive_pkg::ST_RUN && next_state == drive_pkg::ST_RUN)
			|=> (out_freq <= $past(out_freq) + $past(accel_step));
	endproperty
	a_ramp: assert property (p_ramp) else $error("frequency jumped"); //RULE20
endmodule
`default_nettype wire

// ===== hw/drive_pkg.sv
// Types shared by the drive control block.
// Assumes drive_defines.svh supplies the numeric constants.
package drive_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START_DC = 3'b001,
		ST_RUN = 3'b010,
		ST_DECEL = 3'b011,
		ST_BRAKE_WAIT = 3'b100,
		ST_BRAKE_DC = 3'b101,
		ST_HOLD_DC = 3'b110
	} drive_state_e;
endpackage
